/* burst_sram_pkg.sv */
// Constants and types shared by the burst SRAM access logic and its array.
// Assumes one 25 MHz rising-edge clock and a synchronous active-high reset.
package burst_sram_pkg;

  localparam int unsigned ADDR_W     = 17;
  localparam int unsigned LANES      = 2;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANE_DQ_W  = 8;
  localparam int unsigned WORD_W     = LANES * LANE_W;
  localparam int unsigned DQ_W       = LANES * LANE_DQ_W;
  localparam int unsigned DEPTH      = 131072;
  localparam int unsigned BURST_W    = 2;
  localparam int unsigned BUF_DEPTH  = 2;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // Sleep entry and exit, in clock cycles
  localparam int unsigned SLEEP_ENTER_CYC = 2;
  localparam int unsigned SLEEP_EXIT_CYC  = 2;

  // Burst order strap level that selects the interleaved sequence
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // Values after reset
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic               ACTIVE_RST    = 1'b0;

  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b00,
    SLP_ENTER  = 2'b01,
    SLP_ASLEEP = 2'b10,
    SLP_EXIT   = 2'b11
  } sleep_state_t;

endpackage

/* mem_port_if.sv */
// Port between the access logic and its storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mem_port_if #(
  parameter int unsigned AW    = 17,
  parameter int unsigned LANES = 2,
  parameter int unsigned LW    = 9
);
  logic [AW-1:0]       addr;
  logic                rd_en;
  logic [LANES-1:0]    wr_lane;
  logic [LANES*LW-1:0] wdata;
  logic [LANES*LW-1:0] rdata;

  modport ctrl  (output addr, output rd_en, output wr_lane, output wdata, input rdata);
  modport array (input addr, input rd_en, input wr_lane, input wdata, output rdata);
endinterface

/* sram_array.sv */
// Word-wide storage with per-lane write enables and a registered read port.
// Assumes the controller never reads and writes in the same cycle.
`timescale 1ns/1ps
module sram_array #(
  parameter int unsigned DEPTH = 131072,
  parameter int unsigned AW    = 17,
  parameter int unsigned LANES = 2,
  parameter int unsigned LW    = 9
) (
  input  wire logic  ref_clk_i,
  mem_port_if.array  port
);

  logic [LANES*LW-1:0] store [DEPTH];
  logic [LANES*LW-1:0] rdata_r;

  // Unselected lanes keep their contents
  always_ff @(posedge ref_clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (port.wr_lane[l]) begin
        store[port.addr][l*LW +: LW] <= port.wdata[l*LW +: LW];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (port.rd_en) begin
      rdata_r <= store[port.addr];
    end
  end

  assign port.rdata = rdata_r;

endmodule

/* pipelined_burst_sram_access.sv */
// Synchronous access logic of a pipelined common-I/O burst SRAM with
// double-cycle deselect, a two-bit burst counter and a sleep input.
// Assumes all inputs are synchronous to ref_clk_i; the output enable acts
// combinationally on the data drivers.
`timescale 1ns/1ps

// Contract
// - Processor strobe with chip selected loads address; writes and step ignored.
// - Processor-strobe write completes on second clock; global write writes all bytes.
// - Without global write, only lanes selected under byte write gate are written.
// - Data drivers off whenever a write cycle is detected, regardless of enable.
// - Controller strobe write completes in one cycle at new address.
// - Two-bit wraparound counter from low address bits feeds reads and writes.
// - Burst step low during a burst advances to the next address.
// - Strap high selects interleaved order: first address XOR count.
// - Strap low selects linear order: first address plus count modulo four.
// - Sleep keeps data, outputs off; entry and exit take two cycles.
// - Access pending at sleep entry is dropped, no completion guaranteed.
// - Processor strobe always starts a read, whatever the write inputs.
// - Write indication: global write low, or gate low with any lane low.
// - Output enable is asynchronous, masked in writes, needs device selected.
// - New burst from external address when selected with either strobe.
// - Strobes high, step low: continue burst at next address, read or write.
// - Strobes high, step high: suspend, repeat current address.
// - Deselect conditions turn the device off.
// - Read data pass an output register, appearing one clock after address.
// - After deselect, outputs stay driven one more cycle.
module pipelined_burst_sram_access #(
  parameter int unsigned DEPTH = burst_sram_pkg::DEPTH,
  parameter int unsigned AW    = burst_sram_pkg::ADDR_W
) (
  input  wire logic                                 ref_clk_i,
  input  wire logic                                 reset_i,
  input  wire logic [AW-1:0]                        addr_i,
  input  wire logic                                 proc_addr_strobe_n_i,
  input  wire logic                                 ctrl_addr_strobe_n_i,
  input  wire logic                                 burst_step_n_i,
  input  wire logic                                 global_write_n_i,
  input  wire logic                                 byte_write_gate_n_i,
  input  wire logic [burst_sram_pkg::LANES-1:0]     byte_lane_sel_n_i,
  input  wire logic                                 chip_sel_one_n_i,
  input  wire logic                                 chip_sel_two_i,
  input  wire logic                                 chip_sel_three_n_i,
  input  wire logic                                 sleep_req_i,
  input  wire logic                                 burst_order_i,
  input  wire logic                                 out_enable_n_i,
  input  wire logic [burst_sram_pkg::DQ_W-1:0]      data_i,
  input  wire logic [burst_sram_pkg::LANES-1:0]     parity_i,
  output logic      [burst_sram_pkg::DQ_W-1:0]      data_o,
  output logic      [burst_sram_pkg::LANES-1:0]     parity_o,
  output logic                                      data_oe_o,
  output logic                                      sleep_active_o,
  output logic      [burst_sram_pkg::WORD_W-1:0]    rd_word_o,
  output logic                                      rd_valid_o,
  input  wire logic                                 rd_ready_i,
  output logic                                      rd_buf_ready_o
);
  import burst_sram_pkg::*;

  mem_port_if #(.AW(AW), .LANES(LANES), .LW(LANE_W)) mem ();

  sram_array #(
    .DEPTH (DEPTH),
    .AW    (AW),
    .LANES (LANES),
    .LW    (LANE_W)
  ) u_array (
    .ref_clk_i (ref_clk_i),
    .port      (mem.array)
  );

  // Sleep sequencing
  sleep_state_t slp_state_r;
  sleep_state_t slp_state_nxt;
  logic         slp_cnt_r;
  logic         slp_cnt_nxt;

  always_comb begin
    slp_state_nxt = slp_state_r;
    slp_cnt_nxt   = slp_cnt_r;
    unique case (slp_state_r)
      SLP_AWAKE: begin
        if (sleep_req_i) begin
          slp_state_nxt = SLP_ENTER;
          slp_cnt_nxt   = 1'b0;
        end
      end
      SLP_ENTER: begin
        slp_cnt_nxt = 1'b1;
        if (slp_cnt_r == 1'(SLEEP_ENTER_CYC - 1)) begin
          slp_state_nxt = SLP_ASLEEP;
          slp_cnt_nxt   = 1'b0;
        end
      end
      SLP_ASLEEP: begin
        if (!sleep_req_i) begin
          slp_state_nxt = SLP_EXIT;
          slp_cnt_nxt   = 1'b0;
        end
      end
      SLP_EXIT: begin
        slp_cnt_nxt = 1'b1;
        if (sleep_req_i) begin
          slp_state_nxt = SLP_ENTER;
          slp_cnt_nxt   = 1'b0;
        end else if (slp_cnt_r == 1'(SLEEP_EXIT_CYC - 1)) begin
          slp_state_nxt = SLP_AWAKE;
          slp_cnt_nxt   = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      slp_state_r <= SLP_AWAKE;
      slp_cnt_r   <= 1'b0;
    end else begin
      slp_state_r <= slp_state_nxt;
      slp_cnt_r   <= slp_cnt_nxt;
    end
  end

  // No access is taken while asleep or while sleep is being requested
  logic awake;
  assign awake = (slp_state_r == SLP_AWAKE) && !sleep_req_i;

  assign sleep_active_o = (slp_state_r != SLP_AWAKE);

  // The strap is held static; it is captured while reset is high
  logic order_r;
  logic order_nxt;
  assign order_nxt = reset_i ? burst_order_i : order_r;

  always_ff @(posedge ref_clk_i) begin
    order_r <= order_nxt;
  end

  // Cycle decode
  logic active_r;
  logic active_nxt;
  logic proc_addr_strobe_n;
  logic ctrl_addr_strobe_n;
  logic ce_ok;
  logic begin_p;
  logic begin_c;
  logic desel;
  logic cont;
  logic wr_ind;
  logic [LANES-1:0] wr_lanes;

  always_comb begin
    // Processor strobe counts only while chip select one is low
    proc_addr_strobe_n    = !proc_addr_strobe_n_i && !chip_sel_one_n_i;
    ctrl_addr_strobe_n    = !ctrl_addr_strobe_n_i;
    ce_ok   = !chip_sel_one_n_i && chip_sel_two_i && !chip_sel_three_n_i;
    begin_p = awake && proc_addr_strobe_n && ce_ok;
    begin_c = awake && !proc_addr_strobe_n && ctrl_addr_strobe_n && ce_ok;
    desel   = awake && !begin_p && !begin_c && (proc_addr_strobe_n || ctrl_addr_strobe_n);
    cont    = awake && active_r && !proc_addr_strobe_n && !ctrl_addr_strobe_n;
    wr_ind  = !global_write_n_i || (!byte_write_gate_n_i && (|(~byte_lane_sel_n_i)));
    if (!global_write_n_i) begin
      wr_lanes = '1;
    end else if (!byte_write_gate_n_i) begin
      wr_lanes = ~byte_lane_sel_n_i;
    end else begin
      wr_lanes = '0;
    end
  end

  // Burst address state
  logic [AW-1:0]        base_r;
  logic [AW-1:0]        base_nxt;
  logic [BURST_W-1:0]   cnt_r;
  logic [BURST_W-1:0]   cnt_nxt;
  logic [BURST_W-1:0]   low_bits;
  logic [AW-1:0]        acc_addr;
  logic                 do_write;
  logic                 do_read;

  always_comb begin
    active_nxt = active_r;
    base_nxt   = base_r;
    cnt_nxt    = cnt_r;
    if (begin_p || begin_c) begin
      active_nxt = 1'b1;
      base_nxt   = addr_i;
      cnt_nxt    = BURST_CNT_RST;
    end else if (desel || !awake) begin
      active_nxt = 1'b0;
    end else if (cont && !burst_step_n_i) begin
      cnt_nxt = cnt_r + 2'h1;
    end
    // Counter unchanged on a suspend
    if (order_r == ORDER_INTERLEAVED) begin
      low_bits = base_nxt[BURST_W-1:0] ^ cnt_nxt;
    end else begin
      low_bits = base_nxt[BURST_W-1:0] + cnt_nxt;
    end
    acc_addr = {base_nxt[AW-1:BURST_W], low_bits};
    // A processor strobe ignores the write inputs and always reads
    do_read  = begin_p || ((begin_c || cont) && !wr_ind);
    do_write = (begin_c || cont) && wr_ind;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      active_r <= ACTIVE_RST;
      base_r   <= '0;
      cnt_r    <= BURST_CNT_RST;
    end else begin
      active_r <= active_nxt;
      base_r   <= base_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  // The second clock of a processor-strobe write is a continue or suspend cycle
  assign mem.addr    = acc_addr;
  assign mem.rd_en   = do_read;
  assign mem.wr_lane = do_write ? wr_lanes : '0;
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      mem.wdata[l*LANE_W +: LANE_W] = {parity_i[l], data_i[l*LANE_DQ_W +: LANE_DQ_W]};
    end
  end

  // Output pipeline: the array register holds the word after the address
  // edge, the output register presents it one edge later.
  logic              rd_issued_r;
  logic              rd_issued_nxt;
  logic              out_en_r;
  logic              out_en_nxt;
  logic [WORD_W-1:0] out_word_r;
  logic [WORD_W-1:0] out_word_nxt;

  always_comb begin
    rd_issued_nxt = do_read;
    // Deselect stops new reads only, so drivers stay on one more cycle
    out_en_nxt    = rd_issued_r && awake;
    out_word_nxt  = rd_issued_r ? mem.rdata : out_word_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_issued_r <= 1'b0;
      out_en_r    <= 1'b0;
      out_word_r  <= '0;
    end else begin
      rd_issued_r <= rd_issued_nxt;
      out_en_r    <= out_en_nxt;
      out_word_r  <= out_word_nxt;
    end
  end

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      data_o[l*LANE_DQ_W +: LANE_DQ_W] = out_word_r[l*LANE_W +: LANE_DQ_W];
      parity_o[l]                      = out_word_r[l*LANE_W + LANE_DQ_W];
    end
  end

  // Output enable is combinational; any write cycle seen on the pins forces
  // the drivers off, which protects against a master that turns late.
  logic write_seen;
  assign write_seen = awake && (begin_c || cont) && wr_ind;
  assign data_oe_o  = out_en_r && !out_enable_n_i && !write_seen && !sleep_active_o
                      && !sleep_req_i;

  // Two-entry buffer copying each read word to the side port. Its ready is
  // exported: a reader that lets it fill must hold off further reads.
  logic [WORD_W-1:0] buf_r [BUF_DEPTH];
  logic [WORD_W-1:0] buf_nxt [BUF_DEPTH];
  logic              wr_ptr_r;
  logic              wr_ptr_nxt;
  logic              rd_ptr_r;
  logic              rd_ptr_nxt;
  logic [1:0]        fill_r;
  logic [1:0]        fill_nxt;
  logic              push;
  logic              pop;

  always_comb begin
    buf_nxt    = buf_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    fill_nxt   = fill_r;
    push       = rd_issued_r && (fill_r != 2'(BUF_DEPTH));
    pop        = rd_ready_i && (fill_r != 2'h0);
    if (push) begin
      buf_nxt[wr_ptr_r] = mem.rdata;
      wr_ptr_nxt        = !wr_ptr_r;
    end
    if (pop) begin
      rd_ptr_nxt = !rd_ptr_r;
    end
    if (push && !pop) begin
      fill_nxt = fill_r + 2'h1;
    end else if (pop && !push) begin
      fill_nxt = fill_r - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fill_r   <= 2'h0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      fill_r   <= fill_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    buf_r <= buf_nxt;
  end

  assign rd_word_o      = buf_r[rd_ptr_r];
  assign rd_valid_o     = (fill_r != 2'h0);
  assign rd_buf_ready_o = (fill_r != 2'(BUF_DEPTH));

endmodule

/* burst_access_checker.sv */
// Concurrent checks on the pins of the burst SRAM access logic.
// Assumes one clock and the synchronous active-high reset of that block.
`timescale 1ns/1ps
module burst_access_checker (
  input  wire logic                               ref_clk_i,
  input  wire logic                               reset_i,
  input  wire logic                               proc_addr_strobe_n_i,
  input  wire logic                               ctrl_addr_strobe_n_i,
  input  wire logic                               global_write_n_i,
  input  wire logic                               byte_write_gate_n_i,
  input  wire logic [burst_sram_pkg::LANES-1:0]   byte_lane_sel_n_i,
  input  wire logic                               chip_sel_one_n_i,
  input  wire logic                               chip_sel_two_i,
  input  wire logic                               chip_sel_three_n_i,
  input  wire logic                               sleep_req_i,
  input  wire logic                               out_enable_n_i,
  input  wire logic                               data_oe_o,
  input  wire logic                               sleep_active_o,
  input  wire logic [burst_sram_pkg::WORD_W-1:0]  rd_word_o,
  input  wire logic                               rd_valid_o,
  input  wire logic                               rd_ready_i,
  input  wire logic                               rd_buf_ready_o
);
  import burst_sram_pkg::*;
  logic sel, wr_ind, beg_p, beg_cw, desel;
  assign sel    = !chip_sel_one_n_i && chip_sel_two_i && !chip_sel_three_n_i;
  assign wr_ind = !global_write_n_i || (!byte_write_gate_n_i && !(&byte_lane_sel_n_i));
  assign beg_p  = sel && !proc_addr_strobe_n_i && !sleep_req_i && !sleep_active_o;
  assign beg_cw = sel && proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && wr_ind;
  assign desel  = chip_sel_one_n_i && !ctrl_addr_strobe_n_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // The read taken before a deselect still owns the drivers for one cycle
  sequence s_read_desel;
    beg_p ##1 desel ##1 (!out_enable_n_i && !sleep_req_i && !wr_ind);
  endsequence
  sequence s_two_desel;
    desel ##1 desel;
  endsequence
  chk_write_drv_off: assert property (beg_cw |-> !data_oe_o)
    else $error("drivers on in a write cycle");
  chk_oe_gate_off: assert property (out_enable_n_i |-> !data_oe_o)
    else $error("drivers on with output enable high");
  chk_sleep_drv_off: assert property (sleep_req_i |-> !data_oe_o)
    else $error("drivers on while sleep requested");
  chk_desel_stays_on: assert property (s_read_desel |-> data_oe_o)
    else $error("drivers off too early after deselect");
  chk_desel_turns_off: assert property (s_two_desel |=> !data_oe_o)
    else $error("drivers still on after deselect");
  chk_sleep_enter: assert property (sleep_req_i && !sleep_active_o |=> sleep_active_o)
    else $error("sleep state not entered");
  chk_sleep_exit_min: assert property ($fell(sleep_req_i) && sleep_active_o |=> sleep_active_o)
    else $error("sleep left in under two cycles");
  chk_sleep_exit_max: assert property (!sleep_req_i [*8] |-> !sleep_active_o)
    else $error("sleep state never left");
  chk_read_copy: assert property (beg_p ##1 (rd_buf_ready_o && !sleep_req_i) |=> rd_valid_o)
    else $error("read word not copied to buffer");
  chk_buf_hold: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_word_o))
    else $error("buffer head lost during stall");
endmodule

bind pipelined_burst_sram_access burst_access_checker u_burst_access_checker (.*);

/* bus_master.sv */
// Processor-side bus model: each call of cyc drives one clock of the bus.
// Assumes every call starts just after a falling edge of ref_clk_i.
`timescale 1ns/1ps
module bus_master (
  input  wire logic                               ref_clk_i,
  output logic      [burst_sram_pkg::ADDR_W-1:0]  addr_o,
  output logic                                    proc_addr_strobe_n_o,
  output logic                                    ctrl_addr_strobe_n_o,
  output logic                                    burst_step_n_o,
  output logic                                    global_write_n_o,
  output logic                                    byte_write_gate_n_o,
  output logic      [burst_sram_pkg::LANES-1:0]   byte_lane_sel_n_o,
  output logic                                    chip_sel_one_n_o,
  output logic                                    chip_sel_two_o,
  output logic                                    chip_sel_three_n_o,
  output logic                                    sleep_req_o,
  output logic                                    out_enable_n_o,
  output logic      [burst_sram_pkg::DQ_W-1:0]    data_o,
  output logic      [burst_sram_pkg::LANES-1:0]   parity_o
);
  import burst_sram_pkg::*;
  // A careless master leaves the output enable low through its writes
  logic oe_late;
  initial begin
    oe_late = 1'b0;
    {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, chip_sel_one_n_o, burst_step_n_o} = 4'hF;
    {global_write_n_o, byte_write_gate_n_o, byte_lane_sel_n_o} = 4'hF;
    {chip_sel_two_o, chip_sel_three_n_o, sleep_req_o, out_enable_n_o} = 4'h4;
    addr_o = '0;
    {data_o, parity_o} = '0;
  end
  // Control byte, all active low: proc strobe, ctrl strobe, select one, step,
  // global write, byte gate, two lane selects
  task automatic cyc(input logic [7:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DQ_W-1:0] d, input logic [LANES-1:0] p);
    logic wr;
    wr = !c[3] || (!c[2] && !(&c[1:0]));
    if (wr && !oe_late) out_enable_n_o = 1'h1;
    #1;
    {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, chip_sel_one_n_o, burst_step_n_o} = c[7:4];
    {global_write_n_o, byte_write_gate_n_o, byte_lane_sel_n_o} = c[3:0];
    chip_sel_two_o = !c[5];
    chip_sel_three_n_o = c[5];
    addr_o = a;
    // Released lines do not keep their last level
    {data_o, parity_o} = wr ? {d, p} : ~{data_o, parity_o};
    out_enable_n_o = wr && !oe_late;
    @(negedge ref_clk_i);
  endtask
  task automatic late(input logic v);
    oe_late = v;
  endtask
  task automatic slp(input logic s);
    {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, chip_sel_one_n_o} = 3'h7;
    sleep_req_o = s;
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the burst SRAM access logic and its bus master.
// Assumes the checker binds itself to the design from its own file.
`timescale 1ns/1ps
module tb_top;
  import burst_sram_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 17'h1FFFC;
  logic                ref_clk_i, reset_i, burst_order_i, rd_ready_i, out_enable_n_i, sleep_req_i;
  logic [ADDR_W-1:0]   addr_i;
  logic                proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_step_n_i;
  logic                global_write_n_i, byte_write_gate_n_i;
  logic                chip_sel_one_n_i, chip_sel_two_i, chip_sel_three_n_i;
  logic [LANES-1:0]    byte_lane_sel_n_i, parity_i, parity_o;
  logic [DQ_W-1:0]     data_i, data_o;
  logic                data_oe_o, sleep_active_o, rd_valid_o, rd_buf_ready_o;
  logic [WORD_W-1:0]   rd_word_o, em [4];
  int                  failures, checks_done;
  // Row: burst order strap, first low address bits, then the four low address bits in order
  logic [10:0] rows [8] = '{11'h41B, 11'h54E, 11'h6B1, 11'h7E4, 11'h01B, 11'h16C, 11'h2B1, 11'h3C6};

  pipelined_burst_sram_access u_pipelined_burst_sram_access (.*);
  bus_master u_bus_master (.ref_clk_i, .addr_o(addr_i), .proc_addr_strobe_n_o(proc_addr_strobe_n_i),
    .ctrl_addr_strobe_n_o(ctrl_addr_strobe_n_i), .burst_step_n_o(burst_step_n_i),
    .global_write_n_o(global_write_n_i), .byte_write_gate_n_o(byte_write_gate_n_i),
    .byte_lane_sel_n_o(byte_lane_sel_n_i), .chip_sel_one_n_o(chip_sel_one_n_i),
    .chip_sel_two_o(chip_sel_two_i), .chip_sel_three_n_o(chip_sel_three_n_i), .sleep_req_o(sleep_req_i),
    .out_enable_n_o(out_enable_n_i), .data_o(data_i), .parity_o(parity_i));

  always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [WORD_W-1:0] lw(input logic [WORD_W-1:0] e);
    return {e[17], e[15:8], e[16], e[7:0]};
  endfunction
  task automatic cyc(input logic [7:0] c, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
    u_bus_master.cyc(c, a, e[15:0], e[17:16]);
  endtask
  // The strap is only taken while reset is high
  task automatic rst(input logic m);
    burst_order_i = m;
    reset_i = 1'h1;
    cyc(8'hBF, BASE, '0);
    cyc(8'hBF, BASE, '0);
    reset_i = 1'h0;
  endtask
  task automatic rd(input logic [1:0] k);
    cyc(8'h5F, BASE | 17'(k), '0);
    cyc(8'hBF, BASE, '0);
    chk({parity_o, data_o}, em[k]);
    chk(data_oe_o, 32'h1);
    cyc(8'hBF, BASE, '0);
    chk(data_oe_o, 32'h0);
  endtask

  initial begin
    repeat (2000) @(posedge ref_clk_i);
    failures++;
    end_sim();
  end

  initial begin
    {ref_clk_i, reset_i, burst_order_i, rd_ready_i} = 4'h7;
    @(negedge ref_clk_i);
    rst(1'h1);
    for (int k = 0; k < 4; k++) begin
      em[k] = {2'(~k), 8'(8'hA0 + k), 8'(8'h50 + k)};
      cyc(8'h97, BASE | 17'(k), em[k]);
    end
    foreach (rows[i]) begin
      rst(rows[i][10]);
      cyc(8'h5F, BASE | 17'(rows[i][9:8]), '0);
      for (int k = 3; k >= 0; k--) begin
        cyc(8'hCF, BASE, '0);
        chk({parity_o, data_o}, em[rows[i][2*k +: 2]]);
      end
    end
    cyc(8'h57, BASE, ~em[0]);
    cyc(8'hBF, BASE, '0);
    rd(2'h0);
    cyc(8'h5F, BASE | 17'h1, '0);
    cyc(8'hD7, BASE, 18'h21234);
    em[1] = 18'h21234;
    cyc(8'hBF, BASE, '0);
    rd(2'h1);
    cyc(8'h9A, BASE | 17'h2, 18'h1BEEF);
    em[2] = {em[2][17], 1'h1, em[2][15:8], 8'hEF};
    cyc(8'h9B, BASE | 17'h3, 18'h3FFFF);
    cyc(8'h97, BASE, em[0]);
    cyc(8'hC7, BASE, 18'h07E81);
    em[1] = 18'h07E81;
    cyc(8'hBF, BASE, '0);
    rd(2'h2);
    rd(2'h3);
    rd(2'h1);
    cyc(8'hFF, BASE, '0);
    u_bus_master.slp(1'h1);
    repeat (4) cyc(8'hFF, BASE, '0);
    chk(sleep_active_o, 32'h1);
    u_bus_master.slp(1'h0);
    repeat (4) cyc(8'hFF, BASE, '0);
    chk(sleep_active_o, 32'h0);
    // Writes right behind reads with the output enable left low
    u_bus_master.late(1'h1);
    cyc(8'h5F, BASE, '0);
    cyc(8'hCF, BASE, '0);
    chk(data_oe_o, 32'h1);
    cyc(8'h97, BASE | 17'h2, em[2]);
    chk(data_oe_o, 32'h0);
    cyc(8'hCF, BASE, '0);
    cyc(8'hC7, BASE, em[0]);
    chk(data_oe_o, 32'h0);
    u_bus_master.late(1'h0);
    cyc(8'hBF, BASE, '0);
    rd(2'h0);
    // Stall the consumer: the third copy finds the buffer full
    rd_ready_i = 1'h0;
    rd(2'h0);
    rd(2'h3);
    rd(2'h2);
    chk(rd_buf_ready_o, 32'h0);
    rd_ready_i = 1'h1;
    chk(rd_word_o, lw(em[0]));
    @(negedge ref_clk_i);
    chk(rd_word_o, lw(em[3]));
    @(negedge ref_clk_i);
    chk(rd_valid_o, 32'h0);
    end_sim();
  end
endmodule
